/* File: hw/flash_protect_regs.vh */
`ifndef FLASH_PROTECT_REGS_VH
`define FLASH_PROTECT_REGS_VH
`define SECTOR_SIZE_KB      4
`define SECTOR0_BASE        16'hF000
`define SECTOR1_BASE        16'hE000
`define SECTOR_FIXED_MASK   16'hF000
`define SECT_FIXED_LAST     16'hFFFF
`define PROG_CTRL_ADDR      16'h0029
`define PROG_CTRL_RESET     8'h00
`define ERASED_BYTE         8'hFF
`define MODE_TOOL           2'h0
`define MODE_ICP            2'h1
`define MODE_IAP            2'h2
`define MODE_NONE           2'h3
`define OPT_RDP_BIT         0
`define SIZE_4K             16'h1000
`define SIZE_8K             16'h2000
`endif

/* File: hw/flash_sector_protection.v */
// What this block does
// - Each sector erases and reprograms alone; other sectors keep their data.
// - Erase whole array or one sector; program one byte per request.
// - Sectors 0 and 1 are 4 Kbytes each at the top of address space.
// - Sector 0 spans F000h-FFFFh, holding reset and interrupt vectors.
// - 4K has sector 0, 8K sectors 0-1, larger arrays sectors 0-2.
// - Tool and in-circuit modes may program or erase all sectors and options; under read-out protection only the option byte.
// - In-application mode refuses any write or erase of sector 0.
// - Read-out protection blocks external reads of the array and all array writes.
// - Removing read-out protection erases the whole program memory; the erase starts in the same cycle the bit clears.
// - Read-out protection comes from one bit in the option byte.
// - Programming control/status register at 0029h resets to 00h.
`timescale 1ns/100ps
`default_nettype none
`include "flash_protect_regs.vh"

module flash_sector_protection #(
	parameter [15:0] FLASH_SIZE = 16'h8000
) (
	input  wire        clock,
	input  wire        arst_n,
	input  wire [1:0]  prog_mode,
	input  wire        req_valid,
	input  wire        req_erase,
	input  wire        req_mass,
	input  wire        req_option,
	input  wire [15:0] req_addr,
	input  wire [7:0]  req_data,
	input  wire        ext_read,
	input  wire [15:0] ext_addr,
	input  wire        ctrl_wr,
	input  wire [7:0]  ctrl_wdata,
	output wire        op_start,
	output wire        op_erase,
	output wire [1:0]  op_sector,
	output wire        op_all,
	output wire [15:0] op_addr,
	output wire [7:0]  op_data,
	output wire        op_option,
	output wire        req_refused,
	output wire        read_allowed,
	output wire        readout_protect_option_bit,
	output wire [7:0]  prog_ctrl_status
);

	// Sector count follows the array size
	localparam [1:0]  NUM_SECTORS = (FLASH_SIZE <= `SIZE_4K) ? 2'h1 :
		(FLASH_SIZE <= `SIZE_8K) ? 2'h2 : 2'h3;
	localparam [15:0] FLASH_BASE  = 16'h0000 - FLASH_SIZE;
	localparam        MAX_SECTORS = 3;

	wire [MAX_SECTORS-1:0] sector_hit;
	wire                   in_array;
	wire                   ext_in_array;
	wire                   mode_off;
	wire                   mode_iap;
	wire                   mode_ext;
	wire                   rdp_block;
	wire                   option_block;
	wire                   iap_block;
	wire                   range_block;
	wire                   accept;
	wire                   removal;
	reg  [1:0]             sector;
	reg                    rdp_next;
	reg                    op_erase_next;
	reg                    op_all_next;
	reg                    op_option_next;

	reg                    op_start_reg;
	reg                    op_erase_reg;
	reg  [1:0]             op_sector_reg;
	reg                    op_all_reg;
	reg  [15:0]            op_addr_reg;
	reg  [7:0]             op_data_reg;
	reg                    op_option_reg;
	reg                    req_refused_reg;
	reg                    read_allowed_reg;
	reg                    rdp_reg;
	reg  [7:0]             ctrl_status_reg;

	// One address window per sector, top of the map down
	genvar idx;
	generate
		for (idx = 0; idx < MAX_SECTORS; idx = idx + 1) begin : g_sector
			localparam [15:0] WIN_LOW  = (idx == 0) ? `SECTOR0_BASE :
				(idx == 1) ? `SECTOR1_BASE : FLASH_BASE;
			localparam [15:0] WIN_HIGH = (idx == 0) ? `SECT_FIXED_LAST :
				(idx == 1) ? (`SECTOR0_BASE - 16'h0001) : (`SECTOR1_BASE - 16'h0001);
			// Windows beyond the array size never match
			assign sector_hit[idx] = (idx < NUM_SECTORS) &&
				(req_addr >= WIN_LOW) &&
				(req_addr <= WIN_HIGH);
		end
	endgenerate

	assign in_array     = |sector_hit;
	assign ext_in_array = (ext_addr >= FLASH_BASE);

	always @* begin
		sector = 2'h2;
		if (sector_hit[0]) begin
			sector = 2'h0;
		end else if (sector_hit[1]) begin
			sector = 2'h1;
		end else begin
			sector = 2'h2;
		end
	end

	assign mode_off     = (prog_mode == `MODE_NONE);
	assign mode_iap     = (prog_mode == `MODE_IAP);
	assign mode_ext     = (prog_mode == `MODE_TOOL) || (prog_mode == `MODE_ICP);
	// Only the option byte stays writable under protection, and only from outside
	assign rdp_block    = rdp_reg && !(req_option && mode_ext);
	assign option_block = req_option && !mode_ext;
	assign iap_block    = mode_iap && (req_mass || sector_hit[0]);
	assign range_block  = !req_option && !req_mass && !in_array;
	assign accept       = req_valid && !mode_off && !rdp_block &&
		!option_block && !iap_block && !range_block;

	always @* begin
		rdp_next = rdp_reg;
		if (accept && req_option && !req_erase) begin
			rdp_next = req_data[`OPT_RDP_BIT];
		end
	end

	// Dropping protection turns the option write into a whole-array erase
	assign removal = accept && req_option && rdp_reg && !rdp_next;

	always @* begin
		op_erase_next  = req_erase;
		op_all_next    = req_erase && req_mass;
		op_option_next = req_option;
		if (removal) begin
			op_erase_next  = 1'b1;
			op_all_next    = 1'b1;
			op_option_next = 1'b1;
		end
	end

	// Operation handed to the array one cycle after the request
	always @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			op_start_reg    <= 1'b0;
			op_erase_reg    <= 1'b0;
			op_sector_reg   <= 2'h0;
			op_all_reg      <= 1'b0;
			op_addr_reg     <= 16'h0000;
			op_data_reg     <= 8'h00;
			op_option_reg   <= 1'b0;
			req_refused_reg <= 1'b0;
		end else begin
			op_start_reg    <= accept;
			req_refused_reg <= req_valid && !accept;
			op_erase_reg    <= op_erase_next;
			op_all_reg      <= op_all_next;
			op_sector_reg   <= sector;
			op_addr_reg     <= req_addr;
			op_data_reg     <= req_data;
			op_option_reg   <= op_option_next;
		end
	end

	// Read-out protection state
	always @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			rdp_reg <= 1'b0;
		end else begin
			rdp_reg <= rdp_next;
		end
	end

	// Reads outside the array stay open under protection
	always @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			read_allowed_reg <= 1'b0;
		end else begin
			read_allowed_reg <= ext_read && !(rdp_reg && ext_in_array);
		end
	end

	always @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			ctrl_status_reg <= `PROG_CTRL_RESET;
		end else begin
			if (ctrl_wr) begin
				ctrl_status_reg <= ctrl_wdata;
			end
		end
	end

	assign op_start                   = op_start_reg;
	assign op_erase                   = op_erase_reg;
	assign op_sector                  = op_sector_reg;
	assign op_all                     = op_all_reg;
	assign op_addr                    = op_addr_reg;
	assign op_data                    = op_data_reg;
	assign op_option                  = op_option_reg;
	assign req_refused                = req_refused_reg;
	assign read_allowed               = read_allowed_reg;
	assign readout_protect_option_bit = rdp_reg;
	assign prog_ctrl_status           = ctrl_status_reg;

endmodule
`default_nettype wire

/* File: verification/fsp_chk_asserts.sv */
`timescale 1ns/100ps
`default_nettype none
module fsp_chk (
	input wire logic        clock,
	input wire logic        arst_n,
	input wire logic        req_valid,
	input wire logic        req_erase,
	input wire logic        req_mass,
	input wire logic        req_option,
	input wire logic [7:0]  req_data,
	input wire logic        op_start,
	input wire logic        op_erase,
	input wire logic        op_all,
	input wire logic        op_option,
	input wire logic        req_refused,
	input wire logic        read_allowed,
	input wire logic        readout_protect_option_bit,
	input wire logic        ext_read,
	input wire logic [1:0]  prog_mode,
	input wire logic [1:0]  op_sector,
	input wire logic [15:0] req_addr,
	input wire logic [15:0] op_addr,
	input wire logic [15:0] ext_addr
);
	default clocking @(posedge clock); endclocking
	default disable iff (!arst_n);
	sequence s_iap;
		req_valid && prog_mode == 2'h2;
	endsequence
	sequence s_unprotect;
		req_valid && req_option && !req_erase && readout_protect_option_bit &&
			!prog_mode[1] && !req_data[0];
	endsequence
	sequence s_bulk_erase;
		op_start && op_erase && op_all && op_option && !readout_protect_option_bit;
	endsequence
	AST_ANS: assert property (req_valid |=> op_start ^ req_refused)
		else $error("answer");
	AST_IDLE: assert property (!req_valid |=> !op_start)
		else $error("start");
	AST_NONE: assert property (req_valid && &prog_mode |=> req_refused)
		else $error("mode");
	AST_S0: assert property (s_iap ##0 &req_addr[15:12] |=> req_refused)
		else $error("s0");
	AST_MASS: assert property (s_iap ##0 req_mass |=> req_refused)
		else $error("mass");
	AST_RDP: assert property (req_valid && readout_protect_option_bit && !req_option
		|=> req_refused) else $error("rdp");
	AST_SEC0: assert property (op_start && !op_all && &op_addr[15:12]
		|-> op_sector == 2'h0) else $error("sec0");
	AST_SEC1: assert property (op_start && !op_all && op_addr[15:12] == 4'hE
		|-> op_sector == 2'h1) else $error("sec1");
	AST_REMOVE: assert property (s_unprotect |=> s_bulk_erase)
		else $error("remove");
	AST_READ: assert property (ext_read && readout_protect_option_bit && &ext_addr[15:12]
		|=> !read_allowed) else $error("read");
endmodule
bind flash_sector_protection fsp_chk chk_i (.*);
`default_nettype wire

/* File: verification/prog_tool.sv */
`timescale 1ns/100ps
`default_nettype none
module prog_tool (
	input  wire logic        clock,
	output var  logic        req_valid,
	output var  logic        req_erase,
	output var  logic        req_mass,
	output var  logic        req_option,
	output var  logic [1:0]  prog_mode,
	output var  logic [23:0] ad
);
	initial {prog_mode, req_valid, req_erase, req_mass, req_option, ad} = 0;
	// Released address and data lines show the inverse of the last value
	task send(input logic [1:0] m, input logic [2:0] k, input logic [23:0] d);
		@(negedge clock) {prog_mode, req_valid, req_erase, req_mass, req_option, ad} <= {m, 1'b1, k, d};
		@(negedge clock) {req_valid, ad} <= {1'b0, ~d};
	endtask
endmodule
`default_nettype wire

/* File: verification/flash_sector_protection_tb.sv */
`timescale 1ns/100ps
`default_nettype none
module flash_sector_protection_tb;
	logic clock = 0, arst_n = 0, ext_read = 0, ctrl_wr = 0, req_valid, req_erase, req_mass;
	logic req_option, op_start, op_erase, op_all, op_option, req_refused, read_allowed, rdp;
	logic [1:0] prog_mode, op_sector;
	logic [7:0] ctrl_wdata = 0, op_data, prog_ctrl_status;
	logic [15:0] ext_addr = 0, op_addr;
	logic [23:0] ad;
	int miscompares = 0, total_checks = 0;
	initial forever #5 clock = ~clock;
	prog_tool t (.*);
	flash_sector_protection dut (.*, .req_addr(ad[23:8]), .req_data(ad[7:0]),
		.readout_protect_option_bit(rdp));
	task chk(input logic [15:0] s, e);
		total_checks++;
		if (s !== e) begin
			miscompares++;
			$display("MISMATCH %0t got %h expected %h", $time, s, e);
		end
	endtask
	task stop_test;
		if (miscompares == 0 && total_checks > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	task rd(input logic [15:0] a);
		@(negedge clock);
		ext_read <= 1'b1;
		ext_addr <= a;
		@(negedge clock);
		ext_read <= 1'b0;
	endtask
	task t_iap;
		t.send(2, 0, 24'hF00055);
		chk(req_refused, 1);
		t.send(2, 6, 0);
		chk(req_refused, 1);
		t.send(2, 4, 24'hE00000);
		chk({op_start, op_erase, op_sector}, 4'hD);
		chk(op_addr, 16'hE000);
		t.send(2, 0, 24'h9000A5);
		chk({op_start, op_sector, op_data}, 16'h06A5);
	endtask
	task t_tool;
		t.send(0, 0, 24'hFFFF3C);
		chk({op_start, op_sector, op_data}, 16'h043C);
		t.send(1, 6, 0);
		chk({op_start, op_erase, op_all}, 3'h7);
		t.send(3, 0, 24'hE00000);
		chk(req_refused, 1);
	endtask
	task t_rdp;
		t.send(0, 1, 1);
		chk(rdp, 1);
		t.send(1, 4, 24'hE00000);
		chk(req_refused, 1);
		t.send(0, 1, 0);
		chk({op_start, op_all, op_option, rdp}, 4'hE);
	endtask
	task t_read;
		rd(16'hF000);
		chk(read_allowed, 1);
		t.send(0, 1, 1);
		chk(rdp, 1);
		rd(16'hF000);
		chk(read_allowed, 0);
		rd(16'h0029);
		chk(read_allowed, 1);
	endtask
	task t_ctrl_reset;
		@(negedge clock);
		ctrl_wr <= 1'b1;
		ctrl_wdata <= 8'h5A;
		@(negedge clock);
		ctrl_wr <= 1'b0;
		chk(prog_ctrl_status, 8'h5A);
		arst_n = 1'b0;
		@(negedge clock);
		arst_n = 1'b1;
		chk(prog_ctrl_status, 8'h00);
		chk({op_start, rdp}, 2'h0);
		t.send(0, 0, 24'hE0001E);
		chk({op_start, op_sector, op_data}, 16'h051E);
	endtask
	initial begin
		repeat (12) @(posedge clock);
		@(negedge clock) arst_n = 1;
		chk(prog_ctrl_status, 8'h00);
		t_iap;
		t_tool;
		t_rdp;
		t_read;
		t_ctrl_reset;
		stop_test;
	end
	initial begin
		#5000;
		miscompares++;
		stop_test;
	end
endmodule
`default_nettype wire
